/* File: design/scms_consts.vh */
// Constants of the system clock multiplier select block
`ifndef SCMS_CONSTS_VH
`define SCMS_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SCMS_OFS_PMR     8'h00
`define SCMS_OFS_CTRL    8'h04
`define SCMS_OFS_FACTOR  8'h08
`define SCMS_OFS_TICKCFG 8'h0C
`define SCMS_OFS_STATUS  8'h10
`define SCMS_OFS_IRQ_ST  8'h14
`define SCMS_OFS_IRQ_MSK 8'h18

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCMS_CDS_HI      7
`define SCMS_CDS_LO      6
`define SCMS_EN_BIT      0
`define SCMS_FAC_BIT     0
`define SCMS_TXM_BIT     0
`define SCMS_T2M_BIT     1
`define SCMS_SM2_BIT     2
`define SCMS_BAUD_DOUBLER_BIT    3
`define SCMS_IRQ_LOCK    0
`define SCMS_IRQ_REJ     1
`define SCMS_IRQ_SWITCH  2

// ----------------------------------------
// Select codes and reset values
// ----------------------------------------
`define SCMS_CD_MULT     2'h0
`define SCMS_CD_RSVD     2'h1
`define SCMS_CD_DIV4     2'h2
`define SCMS_CD_PMM      2'h3
`define SCMS_RST_CDS     2'h2
`define SCMS_RST_TICKCFG 4'h0
`define SCMS_RST_MASK    3'h0

// ----------------------------------------
// Oscillator cycles per tick
// ----------------------------------------
`define SCMS_P1          15'h0001
`define SCMS_P2          15'h0002
`define SCMS_P3          15'h0003
`define SCMS_P4          15'h0004
`define SCMS_P6          15'h0006
`define SCMS_P12         15'h000C
`define SCMS_P32         15'h0020
`define SCMS_P64         15'h0040
`define SCMS_P512        15'h0200
`define SCMS_P1024       15'h0400
`define SCMS_P3072       15'h0C00
`define SCMS_P8192       15'h2000
`define SCMS_P16384      15'h4000
`define SCMS_MC_DIV      4

// ----------------------------------------
// Multiplier lock interval in oscillator cycles
// ----------------------------------------
`define SCMS_LOCK_CYCLES 65536

`endif

/* File: design/scms_tick_div.v */
// Programmable divider producing a one-cycle tick enable
`timescale 1ns/1ps
module scms_tick_div #(
    parameter PW = 15
) (
    // Clock and reset
    input  wire          pclk,
    input  wire          presetn,
    // Control
    input  wire          restart,
    input  wire [PW-1:0] period,
    // Tick
    output reg           tick_q
);
    reg [PW-1:0] cnt_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q  <= {PW{1'b0}};
            tick_q <= 1'b0;
        end else if (restart) begin
            cnt_q  <= {PW{1'b0}};
            tick_q <= 1'b0;
        end else if (cnt_q >= period - {{(PW-1){1'b0}}, 1'b1}) begin
            cnt_q  <= {PW{1'b0}};
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + {{(PW-1){1'b0}}, 1'b1};
            tick_q <= 1'b0;
        end
    end
endmodule // scms_tick_div

/* File: design/scms_lock_timer.v */
// Multiplier lock interval timer
`timescale 1ns/1ps
module scms_lock_timer #(
    parameter LOCK_CYCLES = 65536,
    parameter CW          = 17
) (
    // Clock and reset
    input  wire pclk,
    input  wire presetn,
    // Control and status
    input  wire enable,
    output reg  ready_q
);
    reg [CW-1:0] cnt_q;
    localparam integer  LAST_I = LOCK_CYCLES - 1;
    localparam [CW-1:0] LAST   = LAST_I[CW-1:0];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= {CW{1'b0}};
            ready_q <= 1'b0;
        end else if (!enable) begin
            cnt_q   <= {CW{1'b0}};
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            if (cnt_q == LAST) begin
                ready_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // scms_lock_timer

/* File: design/scms_top.v */
// System clock source select with multiplier lock protocol and tick generation
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "scms_consts.vh"
module scms_top #(
    parameter LOCK_CYCLES = `SCMS_LOCK_CYCLES,
    parameter LOCK_CW     = 17,
    parameter PW          = 15
) (
    // APB clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Device state
    input  wire        ring_osc_mode_flag,
    // Clock control outputs
    output reg  [1:0]  active_clk_sel,
    output reg         active_mult_factor,
    output wire        mult_enable,
    output wire        mult_lock_ready,
    // Tick enables in oscillator cycles
    output wire        mc_tick,
    output wire        timer_tick,
    output wire        timer2_tick,
    output wire        serial_mode0_tick,
    output wire        serial_mode2_tick,
    // Interrupt
    output reg         irq
);
    // ----------------------------------------
    // Entry sequence states
    // ----------------------------------------
    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_CLR  = 2'h1;
    localparam [1:0] S_FAC  = 2'h2;
    localparam [1:0] S_EN   = 2'h3;

    // ----------------------------------------
    // State
    // ----------------------------------------
    reg  [1:0]    cds_q;
    reg  [1:0]    pend_code_q;
    reg           pend_q;
    reg           mult_en_q;
    reg           fac_q;
    reg  [3:0]    tickcfg_q;
    reg  [1:0]    seq_q;
    reg  [1:0]    seq_d;
    reg  [2:0]    irq_st_q;
    reg  [2:0]    irq_st_d;
    reg  [2:0]    irq_msk_q;
    reg           lock_prev_q;
    reg           restart_q;
    reg  [31:0]   rdata_d;
    reg           addr_ok;
    reg           sel_accept;
    reg           sel_reject;
    reg  [PW-1:0] per_mc;
    reg  [PW-1:0] per_t01;
    reg  [PW-1:0] per_t2;
    reg  [PW-1:0] per_s0;
    reg  [PW-1:0] per_s2;
    wire          lock_w;
    wire [4:0]    tick_w;
    wire [5*PW-1:0] per_w;
    wire          wr_xfer;
    wire [1:0]    new_cds;
    wire          guard;
    wire          entry_ok;
    wire          apply;

    assign wr_xfer  = psel & penable & pwrite & pready;
    assign new_cds  = pwdata[`SCMS_CDS_HI:`SCMS_CDS_LO];
    assign guard    = (cds_q == `SCMS_CD_DIV4) & ~ring_osc_mode_flag;
    assign entry_ok = guard & (seq_q == S_EN) & lock_w;
    assign apply    = pend_q & mc_tick;
    assign mult_enable     = mult_en_q;
    assign mult_lock_ready = lock_w;

    // ----------------------------------------
    // Select write acceptance
    // ----------------------------------------
    always @* begin
        sel_accept = 1'b0;
        sel_reject = 1'b0;
        if (wr_xfer && paddr == `SCMS_OFS_PMR && new_cds != cds_q) begin
            if (new_cds == `SCMS_CD_RSVD) begin
                sel_reject = 1'b1;
            end else if (cds_q == `SCMS_CD_DIV4 && !pend_q) begin
                // Leaving 10 waits until 10 is engaged, so no mode is skipped
                if (new_cds == `SCMS_CD_PMM || entry_ok) begin
                    sel_accept = 1'b1;
                end else begin
                    sel_reject = 1'b1;
                end
            end else if (new_cds == `SCMS_CD_DIV4) begin
                sel_accept = 1'b1;
            end else begin
                sel_reject = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Entry sequence tracking
    // ----------------------------------------
    always @* begin
        seq_d = seq_q;
        if (!guard) begin
            seq_d = S_IDLE;
        end else if (wr_xfer && paddr == `SCMS_OFS_CTRL) begin
            if (!pwdata[`SCMS_EN_BIT]) begin
                seq_d = S_CLR;
            end else if (seq_q == S_FAC) begin
                seq_d = S_EN;
            end else begin
                seq_d = S_IDLE;
            end
        end else if (wr_xfer && paddr == `SCMS_OFS_FACTOR) begin
            if (seq_q == S_CLR || seq_q == S_FAC) begin
                seq_d = S_FAC;
            end else begin
                seq_d = S_IDLE;
            end
        end
        // Other accesses leave the sequence where it is
    end

    // ----------------------------------------
    // Interrupt status, set wins over clear
    // ----------------------------------------
    always @* begin
        irq_st_d = irq_st_q;
        if (wr_xfer && paddr == `SCMS_OFS_IRQ_ST) begin
            irq_st_d = irq_st_q & ~pwdata[2:0];
        end
        if (lock_w && !lock_prev_q) begin
            irq_st_d[`SCMS_IRQ_LOCK] = 1'b1;
        end
        if (sel_reject) begin
            irq_st_d[`SCMS_IRQ_REJ] = 1'b1;
        end
        if (apply) begin
            irq_st_d[`SCMS_IRQ_SWITCH] = 1'b1;
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cds_q          <= `SCMS_RST_CDS;
            pend_code_q    <= `SCMS_RST_CDS;
            pend_q         <= 1'b0;
            active_clk_sel <= `SCMS_RST_CDS;
            active_mult_factor <= 1'b0;
            mult_en_q      <= 1'b0;
            fac_q          <= 1'b0;
            tickcfg_q      <= `SCMS_RST_TICKCFG;
            seq_q          <= S_IDLE;
            irq_st_q       <= 3'h0;
            irq_msk_q      <= `SCMS_RST_MASK;
            lock_prev_q    <= 1'b0;
            restart_q      <= 1'b0;
            irq            <= 1'b0;
        end else begin
            seq_q       <= seq_d;
            irq_st_q    <= irq_st_d;
            lock_prev_q <= lock_w;
            irq         <= |(irq_st_q & irq_msk_q);
            restart_q   <= apply;
            if (wr_xfer && paddr == `SCMS_OFS_CTRL) begin
                mult_en_q <= pwdata[`SCMS_EN_BIT];
            end
            if (wr_xfer && paddr == `SCMS_OFS_FACTOR) begin
                fac_q <= pwdata[`SCMS_FAC_BIT];
            end
            if (wr_xfer && paddr == `SCMS_OFS_TICKCFG) begin
                tickcfg_q <= pwdata[3:0];
            end
            if (wr_xfer && paddr == `SCMS_OFS_IRQ_MSK) begin
                irq_msk_q <= pwdata[2:0];
            end
            if (sel_accept) begin
                cds_q       <= new_cds;
                pend_code_q <= new_cds;
                pend_q      <= 1'b1;
            end else if (apply) begin
                pend_q <= 1'b0;
            end
            if (apply) begin
                active_clk_sel     <= pend_code_q;
                active_mult_factor <= fac_q;
            end
        end
    end

    // ----------------------------------------
    // Tick periods per active mode
    // ----------------------------------------
    always @* begin
        per_t2 = `SCMS_P2;
        per_s2 = tickcfg_q[`SCMS_BAUD_DOUBLER_BIT] ? `SCMS_P32 : `SCMS_P64;
        case (active_clk_sel)
            `SCMS_CD_MULT: begin
                if (!active_mult_factor) begin
                    per_mc  = `SCMS_P2;
                    per_t01 = tickcfg_q[`SCMS_TXM_BIT] ? `SCMS_P12 : `SCMS_P2;
                    per_s0  = tickcfg_q[`SCMS_SM2_BIT] ? `SCMS_P2 : `SCMS_P6;
                end else begin
                    per_mc  = `SCMS_P1;
                    per_t01 = tickcfg_q[`SCMS_TXM_BIT] ? `SCMS_P12 : `SCMS_P1;
                    per_s0  = tickcfg_q[`SCMS_SM2_BIT] ? `SCMS_P1 : `SCMS_P3;
                end
            end
            `SCMS_CD_PMM: begin
                per_mc  = `SCMS_P1024;
                per_t01 = tickcfg_q[`SCMS_TXM_BIT] ? `SCMS_P3072 : `SCMS_P1024;
                per_t2  = `SCMS_P512;
                per_s0  = tickcfg_q[`SCMS_SM2_BIT] ? `SCMS_P1024 : `SCMS_P3072;
                per_s2  = tickcfg_q[`SCMS_BAUD_DOUBLER_BIT] ? `SCMS_P8192 : `SCMS_P16384;
            end
            default: begin
                per_mc  = `SCMS_P4;
                per_t01 = tickcfg_q[`SCMS_TXM_BIT] ? `SCMS_P12 : `SCMS_P4;
                per_s0  = tickcfg_q[`SCMS_SM2_BIT] ? `SCMS_P4 : `SCMS_P12;
            end
        endcase
    end

    assign per_w = {per_s2, per_s0, per_t2, per_t01, per_mc};

    // ----------------------------------------
    // Tick dividers, restarted on each mode switch
    // ----------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_tick
            scms_tick_div #(
                .PW      (PW)
            ) u_div (
                .pclk    (pclk),
                .presetn (presetn),
                .restart (restart_q),
                .period  (per_w[gi*PW +: PW]),
                .tick_q  (tick_w[gi])
            );
        end
    endgenerate

    assign mc_tick           = tick_w[0];
    assign timer_tick        = tick_w[1];
    assign timer2_tick       = tick_w[2];
    assign serial_mode0_tick = tick_w[3];
    assign serial_mode2_tick = tick_w[4];

    // ----------------------------------------
    // Multiplier lock timer
    // ----------------------------------------
    scms_lock_timer #(
        .LOCK_CYCLES (LOCK_CYCLES),
        .CW          (LOCK_CW)
    ) u_lock (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (mult_en_q),
        .ready_q     (lock_w)
    );

    // ----------------------------------------
    // Read data decode
    // ----------------------------------------
    always @* begin
        rdata_d = 32'h0000_0000;
        addr_ok = 1'b1;
        case (paddr)
            `SCMS_OFS_PMR:     rdata_d[`SCMS_CDS_HI:`SCMS_CDS_LO] = cds_q;
            `SCMS_OFS_CTRL:    rdata_d[`SCMS_EN_BIT] = mult_en_q;
            `SCMS_OFS_FACTOR:  rdata_d[`SCMS_FAC_BIT] = fac_q;
            `SCMS_OFS_TICKCFG: rdata_d[3:0] = tickcfg_q;
            `SCMS_OFS_STATUS:  rdata_d[4:0] = {pend_q, active_clk_sel, ring_osc_mode_flag, lock_w};
            `SCMS_OFS_IRQ_ST:  rdata_d[2:0] = irq_st_q;
            `SCMS_OFS_IRQ_MSK: rdata_d[2:0] = irq_msk_q;
            default:           addr_ok = 1'b0;
        endcase
    end

    // ----------------------------------------
    // APB handshake, one wait-free access cycle
    // ----------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (psel && !penable && !pwrite) begin
                prdata <= rdata_d;
            end
        end
    end
endmodule // scms_top

/* File: verification/scms_assertions.sv */
// Port-level checker for the system clock select block
`timescale 1ns/1ps
module scms_checker #(
    parameter LOCK_CYCLES = 65536
) (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // APB
    input wire logic       psel,
    input wire logic       penable,
    input wire logic [7:0] paddr,
    input wire logic       pready,
    input wire logic       pslverr,
    // Clock control
    input wire logic [1:0] active_clk_sel,
    input wire logic       active_mult_factor,
    input wire logic       mult_enable,
    input wire logic       mult_lock_ready,
    input wire logic       mc_tick
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Cycles since the multiplier was enabled
    // ----------------------------------------
    integer en_cnt_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) en_cnt_q <= 0;
        else if (!mult_enable) en_cnt_q <= 0;
        else if (en_cnt_q < LOCK_CYCLES + 8) en_cnt_q <= en_cnt_q + 1;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sel_code_legal_a: assert property (active_clk_sel != 2'h1)
        else $error("reserved select code engaged");
    via_div4_a: assert property ($changed(active_clk_sel) |->
        $past(active_clk_sel) == 2'h2 || active_clk_sel == 2'h2)
        else $error("select changed without passing divide by four");
    mult_locked_a: assert property ($changed(active_clk_sel) && active_clk_sel == 2'h0 |->
        $past(mult_lock_ready) && mult_enable)
        else $error("multiplier engaged without lock");
    engage_on_tick_a: assert property ($changed(active_clk_sel) |-> $past(mc_tick) || $past(mc_tick, 2))
        else $error("select engaged away from a machine cycle");
    lock_low_off_a: assert property (!mult_enable && !$past(mult_enable) |-> !mult_lock_ready)
        else $error("lock ready while multiplier disabled");
    lock_early_a: assert property ($rose(mult_lock_ready) |->
        en_cnt_q >= LOCK_CYCLES - 2 && en_cnt_q <= LOCK_CYCLES + 2)
        else $error("lock ready at wrong time");
    lock_late_a: assert property (en_cnt_q == LOCK_CYCLES + 3 |-> mult_lock_ready)
        else $error("lock ready missing");
    div4_period_a: assert property (mc_tick && active_clk_sel == 2'h2 && $stable(active_clk_sel)
        ##1 active_clk_sel == 2'h2 |-> !mc_tick [*3] ##1 mc_tick)
        else $error("machine cycle not four clocks");
    mult2x_period_a: assert property (mc_tick && active_clk_sel == 2'h0 && !active_mult_factor
        && $stable(active_clk_sel) ##1 active_clk_sel == 2'h0 |-> !mc_tick ##1 mc_tick)
        else $error("machine cycle not two clocks");
    mult4x_period_a: assert property (mc_tick && active_clk_sel == 2'h0 && active_mult_factor
        && $stable(active_clk_sel) ##1 active_clk_sel == 2'h0 |-> mc_tick)
        else $error("machine cycle not one clock");
    zero_wait_a: assert property (psel && !penable |=> pready)
        else $error("access not answered at once");
    unmapped_err_a: assert property (pready && paddr > 8'h18 |-> pslverr)
        else $error("unmapped access without error");
endmodule // scms_checker

/* File: verification/tb_system_clock_multiplier_select.sv */
// Self-checking bench for the system clock select block
`timescale 1ns/1ps
`include "scms_consts.vh"
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin mismatches++; \
    $display("Error %s expected %0h seen %0h", nm, (e), (s)); end end
module tb_system_clock_multiplier_select;
    logic        pclk, presetn, psel, penable, pwrite, ring, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq, mult_enable, mult_lock_ready, fac;
    wire  [1:0]  asel;
    wire  [4:0]  ticks;
    logic [15:0] lfsr = 16'h53EC;
    integer      mismatches = 0, n_checks = 0, cyc = 0;
    integer      m_cds = 2, m_fac = 0, m_cfg = 0, m_step = 0, m_irq = 0, f;

    scms_top #(.LOCK_CYCLES(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ring_osc_mode_flag(ring), .active_clk_sel(asel), .active_mult_factor(fac), .mult_enable(mult_enable),
        .mult_lock_ready(mult_lock_ready), .mc_tick(ticks[0]), .timer_tick(ticks[1]), .timer2_tick(ticks[2]),
        .serial_mode0_tick(ticks[3]), .serial_mode2_tick(ticks[4]), .irq(irq));

    initial begin
        pclk = 0;
        forever #12.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            mismatches++;
            tally_and_finish;
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic integer exp_per(input integer i);
        integer mc;
        mc = (m_cds == 3) ? 1024 : (m_cds == 2) ? 4 : (m_fac ? 1 : 2);
        case (i)
            0: exp_per = mc;
            1: exp_per = m_cfg[0] ? ((m_cds == 3) ? 3072 : 12) : mc;
            2: exp_per = (m_cds == 3) ? 512 : 2;
            3: exp_per = m_cfg[2] ? mc : 3 * mc;
            default: exp_per = ((m_cds == 3) ? 256 : 1) * (m_cfg[3] ? 32 : 64);
        endcase
    endfunction

    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin @(posedge pclk); end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic wreg(input logic [7:0] a, input integer v);
        lfsr = lfsr_next(lfsr);
        apb(1, a, {lfsr, 16'(v)});
        if (a == `SCMS_OFS_CTRL) m_step = v ? ((m_step == 2) ? 3 : 0) : ((m_cds == 2 && !ring) ? 1 : 0);
        else if (a == `SCMS_OFS_FACTOR) begin
            m_step = (m_step == 1 || m_step == 2) ? 2 : 0;
            m_fac = v;
        end
        else m_cfg = v;
    endtask

    task automatic set_sel(input integer c);
        integer ok, k;
        ok = (c != 1) && (c == 2 || m_cds == 2 || c == m_cds);
        if (c == 0 && m_cds != 0) ok = ok && m_step == 3 && !ring;
        if (!ok) m_irq = m_irq | 2;
        else if (c != m_cds) m_irq = m_irq | 4;
        if (ok) m_cds = c;
        if (m_cds != 2) m_step = 0;
        apb(1, `SCMS_OFS_PMR, 32'(c) << 6);
        apb(0, `SCMS_OFS_PMR, 0);
        `CHK("select register", 32'(m_cds) << 6, rd)
        k = 0;
        while (asel !== 2'(m_cds) && k < 3000) begin @(posedge pclk); k++; end
        `CHK("engaged select", 2'(m_cds), asel)
    endtask

    task automatic measure(input integer i, input integer e);
        integer k, n;
        repeat (2) begin
            k = 0;
            do begin @(posedge pclk); k++; end while (ticks[i] !== 1'b1 && k < 20000);
        end
        n = 0;
        do begin @(posedge pclk); n++; end while (ticks[i] !== 1'b1 && n < 20000);
        `CHK("tick period", e, n)
    endtask

    task automatic tick_all(input integer cfg);
        integer i;
        wreg(`SCMS_OFS_TICKCFG, cfg);
        for (i = 0; i < 5; i++) measure(i, exp_per(i));
    endtask

    task automatic wait_lock;
        integer k;
        k = 0;
        do begin apb(0, `SCMS_OFS_STATUS, 0); k++; end while (rd[0] !== 1'b1 && k < 40);
        `CHK("lock ready", 1'b1, rd[0])
        m_irq = m_irq | 1;
    endtask

    task automatic chk_irq;
        apb(0, `SCMS_OFS_IRQ_ST, 0);
        `CHK("irq status", 32'(m_irq), rd)
        `CHK("irq line", m_irq != 0, irq)
        apb(1, `SCMS_OFS_IRQ_ST, 32'(m_irq));
        m_irq = 0;
        repeat (2) @(posedge pclk);
        `CHK("irq cleared", 1'b0, irq)
    endtask

    task automatic enter(input integer fv, input logic rg, input integer skip);
        ring <= rg;
        wreg(`SCMS_OFS_CTRL, 0);
        if (!skip) wreg(`SCMS_OFS_FACTOR, fv);
        apb(0, `SCMS_OFS_STATUS, 0);
        `CHK("lock while disabled", 1'b0, rd[0])
        `CHK("lock pin off", 1'b0, mult_lock_ready)
        `CHK("multiplier disabled", 1'b0, mult_enable)
        apb(0, `SCMS_OFS_TICKCFG, 0);
        `CHK("tick config", 32'(m_cfg), rd)
        wreg(`SCMS_OFS_CTRL, 1);
        wait_lock;
        `CHK("multiplier enable", 1'b1, mult_enable)
        `CHK("lock pin", 1'b1, mult_lock_ready)
        set_sel(0);
        if (m_cds == 0) `CHK("engaged factor", 1'(m_fac), fac)
        ring <= 0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ring = 0;
        presetn = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1;
        apb(0, `SCMS_OFS_PMR, 0);
        `CHK("select reset", 32'h80, rd)
        `CHK("engaged reset", 2'h2, asel)
        apb(0, 8'h40, 0);
        `CHK("unmapped error", 1'b1, err)
        set_sel(1);
        repeat (2) @(posedge pclk);
        `CHK("masked irq", 1'b0, irq)
        apb(1, `SCMS_OFS_IRQ_MSK, 32'h7);
        chk_irq;
        tick_all(0);
        lfsr = lfsr_next(lfsr);
        tick_all(lfsr[3:0]);
        set_sel(3);
        tick_all(4'hE);
        set_sel(0);
        set_sel(2);
        chk_irq;
        enter(0, 1, 0);
        enter(0, 0, 1);
        chk_irq;
        for (f = 0; f < 2; f++) begin
            enter(f, 0, 0);
            lfsr = lfsr_next(lfsr);
            tick_all(lfsr[3:0]);
            set_sel(3);
            set_sel(2);
            chk_irq;
        end
        tally_and_finish;
    end
endmodule // tb_system_clock_multiplier_select

bind scms_top scms_checker #(.LOCK_CYCLES(LOCK_CYCLES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .active_clk_sel(active_clk_sel),
    .active_mult_factor(active_mult_factor), .mult_enable(mult_enable), .mult_lock_ready(mult_lock_ready),
    .mc_tick(mc_tick));
